// file: shared/swf_pkg.sv
// Shared constants and types of the sliding-window input filter
package swf_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Sizes
    localparam int CH_NUM = 4;
    localparam int HIST_DEPTH = 64;
    localparam int SPAN_W = 6;
    localparam int COUNT_W = 7;
    localparam int PSC_W = 16;

    ////////////////////////////////////////////////////////////////////////
    // Register byte addresses
    localparam logic [7:0] ADDR_CFG = 8'h6C;
    localparam logic [7:0] ADDR_SRC = 8'h70;
    localparam logic [7:0] ADDR_STAT = 8'h74;

    ////////////////////////////////////////////////////////////////////////
    // Field positions of the configuration word
    localparam int VOTE_LSB = 24;
    localparam int SPAN_LSB = 17;
    localparam int ON_BIT = 16;
    localparam int PSC_LSB = 0;

    ////////////////////////////////////////////////////////////////////////
    // Values after reset and write masks
    localparam logic [31:0] CFG_RESET = 32'h0000_0000;
    localparam logic [31:0] CFG_WMASK = 32'h3F7F_FFFF;
    localparam logic [3:0] SRC_RESET = 4'h0;
    localparam logic [31:0] RD_IDLE = 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////
    // Configuration register layout
    typedef struct packed {
        logic [1:0] rsv_hi;
        logic [5:0] level_vote_count;
        logic rsv_mid;
        logic [5:0] sample_span;
        logic filter_on;
        logic [15:0] psc;
    } swf_cfg_s;

    // Three-stage synchroniser for a group of channel levels
    typedef struct packed {
        logic [3:0] s1;
        logic [3:0] s2;
        logic [3:0] s3;
    } swf_sync_s;

    // Whole state of the filter top
    typedef struct packed {
        swf_cfg_s cfg;
        logic [3:0] src_sel;
        logic [15:0] psc_cnt;
        logic tick;
        logic decide;
        swf_sync_s pin_sync;
        swf_sync_s alt_sync;
        logic [3:0] pin_lvl;
        logic [3:0] alt_lvl;
        logic [3:0] filt;
        logic [3:0] chan_out;
        logic [31:0] rdata;
    } swf_state_s;

endpackage : swf_pkg

// file: tb/swf_filter_bench.sv
// Self-checking testbench of the sliding-window input filter
`timescale 1ns/1ps

module swf_filter_bench;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic [3:0] pin_source;
    logic [3:0] alt_source = 4'h0;
    logic [3:0] chan_level;
    logic [3:0] pin_level = 4'h0;
    logic [3:0] glitch_mask = 4'h0;
    logic [15:0] glitch_len = 16'h0000;
    logic glitch_go = 1'b0;
    logic [31:0] rv;
    logic [31:0] rdata_pin;
    logic [31:0] rv_pin;
    int fail_count = 0;
    int checks_done = 0;

    ////////////////////////////////////////////////////////////////////////
    // Clock, design and pin model
    always #4 sys_clk = ~sys_clk;

    swf_filter #(.ALT_MASK(4'hF)) dut (.sys_clk(sys_clk), .reset_n(reset_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .pin_source(pin_source), .alt_source(alt_source),
        .chan_level(chan_level));

    // Instance whose only alternate is the comparator on channel one
    swf_filter dut_pin (.sys_clk(sys_clk), .reset_n(reset_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(rdata_pin), .pin_source(pin_source), .alt_source(alt_source),
        .chan_level());

    swf_pin_model pins (.sys_clk(sys_clk), .pin_level(pin_level), .glitch_mask(glitch_mask),
        .glitch_len(glitch_len), .glitch_go(glitch_go), .pin_source(pin_source));

    ////////////////////////////////////////////////////////////////////////
    // Access and compare tasks
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(negedge sys_clk);
        rv = reg_rdata;
        rv_pin = rdata_pin;
    endtask : rd

    // Glitch of len clocks on the masked pins
    task automatic glitch(input logic [3:0] m, input logic [15:0] len);
        @(posedge sys_clk);
        glitch_mask <= m;
        glitch_len <= len;
        glitch_go <= 1'b1;
        @(posedge sys_clk);
        glitch_go <= 1'b0;
    endtask : glitch

    // Masked channel levels hold a value for n cycles
    task automatic stays(input logic [3:0] m, input logic [3:0] e, input int n);
        repeat (n) begin
            @(negedge sys_clk);
            chk("chan_level", {28'h0000000, chan_level & m}, {28'h0000000, e});
        end
    endtask : stays

    // Masked channel levels reach a value within lim cycles
    task automatic wait_lvl(input logic [3:0] m, input logic [3:0] e, input int lim);
        int i;
        i = 0;
        @(negedge sys_clk);
        while (i < lim && (chan_level & m) !== e) begin
            @(negedge sys_clk);
            i++;
        end
        chk("chan_level", {28'h0000000, chan_level & m}, {28'h0000000, e});
    endtask : wait_lvl

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_sim

    ////////////////////////////////////////////////////////////////////////
    // Watchdog against a hang
    initial begin
        #100000;
        fail_count++;
        end_sim();
    end

    ////////////////////////////////////////////////////////////////////////
    // Test sequence
    initial begin
        repeat (3) @(posedge sys_clk);
        reset_n <= 1'b1;
        rd(8'h6C);
        chk("config", rv, 32'h0000_0000);
        rd(8'h70);
        chk("source", rv, 32'h0000_0000);
        rd(8'h80);
        chk("unmapped", rv, 32'h0000_0000);
        wr(8'h6C, 32'hFFFF_FFFF);
        rd(8'h6C);
        chk("config", rv, 32'h3F7F_FFFF);
        wr(8'h6C, 32'h0000_0000);
        // Filter off: six edges from pin to output
        @(posedge sys_clk);
        pin_level <= 4'hF;
        repeat (5) @(posedge sys_clk);
        @(negedge sys_clk);
        chk("chan_level", {28'h0000000, chan_level}, 32'h0000_0000);
        @(negedge sys_clk);
        chk("chan_level", {28'h0000000, chan_level}, 32'h0000_000F);
        // Every clock sampled, window 4, threshold 3
        wr(8'h6C, 32'h0309_0000);
        repeat (10) @(posedge sys_clk);
        glitch(4'h1, 16'h0002);
        stays(4'hF, 4'hF, 12);
        glitch(4'h1, 16'h0003);
        wait_lvl(4'h1, 4'h0, 12);
        wait_lvl(4'h1, 4'h1, 12);
        // Sample every tenth clock, window 4, threshold 4
        wr(8'h6C, 32'h0409_0009);
        repeat (60) @(posedge sys_clk);
        glitch(4'h2, 16'd25);
        stays(4'hF, 4'hF, 45);
        glitch(4'h2, 16'd60);
        wait_lvl(4'h2, 4'h0, 80);
        wait_lvl(4'h2, 4'h2, 80);
        // Internal sources bypass the slow filter
        wr(8'h70, 32'h0000_000F);
        rd(8'h70);
        chk("source", rv, 32'h0000_000F);
        chk("source pin only", rv_pin, 32'h0000_0001);
        @(posedge sys_clk);
        alt_source <= 4'h5;
        repeat (8) @(posedge sys_clk);
        @(negedge sys_clk);
        chk("chan_level", {28'h0000000, chan_level}, 32'h0000_0005);
        rd(8'h74);
        chk("status", rv, 32'h0000_05F5);
        wr(8'h70, 32'h0000_0000);
        wait_lvl(4'hF, 4'hF, 20);
        // Sample every third clock, window 4, threshold 3
        wr(8'h6C, 32'h0309_0002);
        rd(8'h6C);
        chk("config", rv, 32'h0309_0002);
        stays(4'hF, 4'hF, 20);
        end_sim();
    end
endmodule : swf_filter_bench

// file: tb/swf_pin_model.sv
// Model of the external pins that feed the four filter channels
`timescale 1ns/1ps

module swf_pin_model (
    // Clock
    input wire logic sys_clk,
    // Steady pin levels and glitch request
    input wire logic [3:0] pin_level,
    input wire logic [3:0] glitch_mask,
    input wire logic [15:0] glitch_len,
    input wire logic glitch_go,
    // Pin levels seen by the filter
    output logic [3:0] pin_source
);
    logic [15:0] glitch_cnt = 16'h0000;

    ////////////////////////////////////////////////////////////////////////
    // Glitch length counter, one system clock per count
    always @(posedge sys_clk) begin
        if (glitch_go) begin
            glitch_cnt <= glitch_len;
        end else if (glitch_cnt != 16'h0000) begin
            glitch_cnt <= glitch_cnt - 16'h0001;
        end
    end

    // Pins invert the selected channels while a glitch lasts
    assign pin_source = pin_level ^ ((glitch_cnt != 16'h0000) ? glitch_mask : 4'h0);
endmodule : swf_pin_model

// file: verilog/swf_filter.sv
// Four-channel sliding-window majority filter with source routing and registers
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps

// Notes on behaviour
// - Threshold field bits 29:24, up to 63
// - Enough high or low samples set output
// - Neither count reaches threshold: output holds
// - Window field bits 22:17, up to 63
// - History is a 64-bit shift store
// - Bit 16 switches the filter on
// - 16-bit prescaler spaces the sample points
// - Only levels at sample points are counted
// - Configuration register resets to all zeros
// - One filter in front of each channel
// - Internal clock sources bypass the filter
// - Channel one selects pin or comparator
module swf_filter #(
    // Channels that own an alternate internal source
    parameter logic [3:0] ALT_MASK = 4'h1
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Pin inputs of the four channels
    input wire logic [3:0] pin_source,
    // Internal alternates: comparator, low-speed ext, low-speed int, fast ext / 128
    input wire logic [3:0] alt_source,
    // Conditioned channel levels toward the capture logic
    output logic [3:0] chan_level
);

    swf_pkg::swf_state_s st_reg;
    swf_pkg::swf_state_s st_next;
    logic [3:0][swf_pkg::HIST_DEPTH-1:0] hist;
    logic [3:0][swf_pkg::COUNT_W-1:0] ones_cnt;
    logic [3:0][swf_pkg::COUNT_W-1:0] zeros_cnt;
    logic [3:0] vote_high;
    logic [3:0] vote_low;
    logic [swf_pkg::COUNT_W-1:0] vote_w;
    logic [swf_pkg::COUNT_W-1:0] span_w;

    ////////////////////////////////////////////////////////////////////////
    // Count of ones in the newest span entries of a history
    function automatic logic [6:0] ones_in(input logic [63:0] h, input logic [5:0] span);
        logic [6:0] c;
        c = 7'h00;
        for (int i = 0; i < swf_pkg::HIST_DEPTH; i++) begin
            if (i < int'(span)) begin
                c = c + {6'h00, h[i]};
            end
        end
        return c;
    endfunction : ones_in

    // Vote threshold and window span widened to the count width
    assign vote_w = {1'b0, st_reg.cfg.level_vote_count};
    assign span_w = {1'b0, st_reg.cfg.sample_span};

    ////////////////////////////////////////////////////////////////////////
    // Per-channel history store and window votes
    for (genvar g = 0; g < swf_pkg::CH_NUM; g++) begin : g_chan
        // One filter history per channel input
        swf_history #(
            .DEPTH(swf_pkg::HIST_DEPTH)
        ) u_hist (
            .sys_clk(sys_clk),
            .reset_n(reset_n),
            .shift_en(st_reg.tick),
            .bit_in(st_reg.pin_lvl[g]),
            .hist_out(hist[g])
        );

        // Ones and zeros inside the window
        assign ones_cnt[g] = ones_in(hist[g], st_reg.cfg.sample_span);
        assign zeros_cnt[g] = span_w - ones_cnt[g];
        assign vote_high[g] = (ones_cnt[g] >= vote_w);
        assign vote_low[g] = (zeros_cnt[g] >= vote_w);
    end

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        st_next = st_reg;

        // Register writes, reserved bits forced to zero
        if (reg_wr && reg_addr == swf_pkg::ADDR_CFG) begin
            st_next.cfg = reg_wdata & swf_pkg::CFG_WMASK;
        end
        if (reg_wr && reg_addr == swf_pkg::ADDR_SRC) begin
            st_next.src_sel = reg_wdata[3:0] & ALT_MASK;
        end

        // Read data stand for one cycle only
        st_next.rdata = swf_pkg::RD_IDLE;
        if (reg_rd) begin
            unique case (reg_addr)
                swf_pkg::ADDR_CFG: st_next.rdata = st_reg.cfg;
                swf_pkg::ADDR_SRC: st_next.rdata = {28'h0000000, st_reg.src_sel};
                swf_pkg::ADDR_STAT: st_next.rdata = {20'h00000, st_reg.alt_lvl,
                    st_reg.pin_lvl, st_reg.chan_out};
                default: st_next.rdata = swf_pkg::RD_IDLE;
            endcase
        end

        // Three-stage synchronisers for pins and alternates
        st_next.pin_sync.s1 = pin_source;
        st_next.pin_sync.s2 = st_reg.pin_sync.s1;
        st_next.pin_sync.s3 = st_reg.pin_sync.s2;
        st_next.alt_sync.s1 = alt_source;
        st_next.alt_sync.s2 = st_reg.alt_sync.s1;
        st_next.alt_sync.s3 = st_reg.alt_sync.s2;

        // Accept a level once the last two stages agree
        for (int i = 0; i < swf_pkg::CH_NUM; i++) begin
            if (st_reg.pin_sync.s2[i] == st_reg.pin_sync.s3[i]) begin
                st_next.pin_lvl[i] = st_reg.pin_sync.s3[i];
            end
            if (st_reg.alt_sync.s2[i] == st_reg.alt_sync.s3[i]) begin
                st_next.alt_lvl[i] = st_reg.alt_sync.s3[i];
            end
        end

        // Prescaler: one tick every psc+1 system clocks
        st_next.tick = 1'b0;
        if (!st_reg.cfg.filter_on) begin
            st_next.psc_cnt = 16'h0000;
        end else if (st_reg.psc_cnt >= st_reg.cfg.psc) begin
            st_next.psc_cnt = 16'h0000;
            st_next.tick = 1'b1;
        end else begin
            st_next.psc_cnt = st_reg.psc_cnt + 16'h0001;
        end

        // Decide one cycle after the history has taken the sample
        st_next.decide = st_reg.tick && st_reg.cfg.filter_on;

        // Level decision per channel
        for (int i = 0; i < swf_pkg::CH_NUM; i++) begin
            if (!st_reg.cfg.filter_on) begin
                st_next.filt[i] = st_reg.pin_lvl[i];
            end else if (st_reg.decide) begin
                if (vote_high[i]) begin
                    st_next.filt[i] = 1'b1;
                end else if (vote_low[i]) begin
                    st_next.filt[i] = 1'b0;
                end else begin
                    st_next.filt[i] = st_reg.filt[i];
                end
            end
        end

        // Source routing: internal sources skip the filter
        for (int i = 0; i < swf_pkg::CH_NUM; i++) begin
            if (st_reg.src_sel[i]) begin
                st_next.chan_out[i] = st_reg.alt_lvl[i];
            end else begin
                st_next.chan_out[i] = st_reg.filt[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs
    assign reg_rdata = st_reg.rdata;
    assign chan_level = st_reg.chan_out;

    ////////////////////////////////////////////////////////////////////////
    // Checks on the filter behaviour
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);

    a_vote_field_wr: assert property (
        reg_wr && reg_addr == swf_pkg::ADDR_CFG
        |=> st_reg.cfg.level_vote_count == $past(reg_wdata[29:24]))
        else $error("Threshold field not taken from bits 29:24");

    a_span_field_wr: assert property (
        reg_wr && reg_addr == swf_pkg::ADDR_CFG
        |=> st_reg.cfg.sample_span == $past(reg_wdata[22:17]))
        else $error("Window field not taken from bits 22:17");

    a_on_field_wr: assert property (
        reg_wr && reg_addr == swf_pkg::ADDR_CFG
        |=> st_reg.cfg.filter_on == $past(reg_wdata[16]) && st_reg.cfg.rsv_hi == 2'h0)
        else $error("Enable bit not taken from bit 16");

    a_high_vote: assert property (
        st_reg.cfg.filter_on && st_reg.decide && vote_high[0]
        |=> st_reg.filt[0] ##1 (st_reg.chan_out[0] || $past(st_reg.src_sel[0])))
        else $error("High majority did not drive output high");

    a_low_vote: assert property (
        st_reg.cfg.filter_on && st_reg.decide && !vote_high[0] && vote_low[0]
        |=> !st_reg.filt[0])
        else $error("Low majority did not drive output low");

    a_hold_level: assert property (
        st_reg.cfg.filter_on && !(st_reg.decide && (vote_high[1] || vote_low[1]))
        |=> st_reg.filt[1] == $past(st_reg.filt[1]))
        else $error("Filter output changed without a majority");

    a_sample_shift: assert property (
        st_reg.tick
        |=> hist[2] == {$past(hist[2][62:0]), $past(st_reg.pin_lvl[2])})
        else $error("History did not shift in the sample");

    a_between_ticks: assert property (
        !st_reg.tick |=> $stable(hist[3]))
        else $error("History changed between sample points");

    a_tick_spacing: assert property (
        st_reg.tick && st_reg.cfg.psc == 16'h0002 && !reg_wr
        ##1 !reg_wr ##1 !reg_wr
        |=> st_reg.tick)
        else $error("Sample tick spacing wrong for divide by three");

    a_filter_off: assert property (
        !st_reg.cfg.filter_on |=> st_reg.filt == $past(st_reg.pin_lvl))
        else $error("Disabled filter does not follow input");

    a_alt_bypass: assert property (
        st_reg.src_sel[0] |=> st_reg.chan_out[0] == $past(st_reg.alt_lvl[0]))
        else $error("Internal source passed through the filter");

    a_alt_allowed: assert property (
        (st_reg.src_sel & ~ALT_MASK) == 4'h0)
        else $error("Alternate source selected on a pin-only channel");

    c_high_vote: cover property (st_reg.decide && vote_high[0] && !st_reg.filt[0]);
    c_low_vote: cover property (st_reg.decide && !vote_high[0] && vote_low[0] && st_reg.filt[0]);
    c_hold_vote: cover property (st_reg.decide && !vote_high[0] && !vote_low[0]);
    c_alt_route: cover property (st_reg.src_sel[0] && st_reg.alt_lvl[0]);

endmodule : swf_filter

// file: verilog/swf_history.sv
// Sample history shift store of one filter channel
`timescale 1ns/1ps

module swf_history #(
    parameter int DEPTH = 64
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Sample entry
    input wire logic shift_en,
    input wire logic bit_in,
    // Registered history, bit 0 is the newest sample
    output logic [DEPTH-1:0] hist_out
);

    typedef struct packed {
        logic [DEPTH-1:0] bits;
    } swf_hist_s;

    swf_hist_s hist_reg;
    swf_hist_s hist_next;

    ////////////////////////////////////////////////////////////////////////
    // Shift one sample in per sample tick only
    always_comb begin
        hist_next = hist_reg;
        if (shift_en) begin
            hist_next.bits = {hist_reg.bits[DEPTH-2:0], bit_in};
        end
    end

    // State register
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            hist_reg <= '0;
        end else begin
            hist_reg <= hist_next;
        end
    end

    assign hist_out = hist_reg.bits;

endmodule : swf_history
